// ---- hw/nsb_bridge.sv ----
// Slot bus slave decode, retry reply and local bus arbitration.
// Assumes slot bus pins on i_ref_clk domain edges, core on i_dma_clk.
//
// Summary of operation
// - Address bits 27..24 equal to the slot id select this board.
// - Whole bus address is latched at cycle start.
// - Bits 19..17 decode to ROM and register group selects.
// - Bits 23..20 are ignored so both addressing modes work.
// - Slave reads and writes use all 32 data lines.
// - Local strobes come from bus timing on the 10 MHz clock.
// - An 8 kbyte configuration ROM is readable in slot space.
// - Interrupts drive the nonmaster interrupt request line.
// - Slave access while local bus is granted gets a RETRY reply.
// - Core requests, interface grants, core starts only after grant.
// - Core cycles outside the board become bus master operations.
// - Core cycles inside the board finish locally at the GPIB part.
// - Core drops request when done, interface then withdraws grant.
// - GPIB controller takes 8 and 16 bit reads and writes.
// - GPIB gets chip select on slave hit to group 0, acknowledge on core hit.
`timescale 1ns/100ps
`include "nsb_defines.svh"
module nsb_bridge
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_dma_clk,
    input wire logic i_bus_start_n,
    input wire logic [31:0] i_bus_ad,
    input wire logic [1:0] i_bus_tm,
    input wire logic [3:0] i_slot_id,
    output logic [31:0] o_bus_ad,
    output logic o_bus_ad_oe_n,
    output logic o_bus_ack,
    output logic [1:0] o_bus_status,
    input wire logic i_board_irq,
    output logic o_nonmaster_interrupt_request,
    output logic o_nonmaster_interrupt_request_oe_n,
    output nsb_pkg::nsb_local_t o_local,
    output logic [7:0] o_group_sel,
    output logic o_gpib_cs,
    output logic o_gpib_dack,
    input wire logic [31:0] i_local_rdata,
    output logic o_master_req,
    output nsb_pkg::nsb_dma_cmd_t o_master_cmd,
    input wire logic i_master_done,
    input wire logic [31:0] i_master_rdata,
    input wire logic i_dma_hold,
    input wire logic i_dma_cmd_valid,
    input wire nsb_pkg::nsb_dma_cmd_t i_dma_cmd,
    output logic o_local_bus_grant,
    output logic o_dma_done,
    output logic [31:0] o_dma_rdata
);
localparam int LCYC = `NSB_LOCAL_CYC;
localparam logic [1:0] LCNT = 2'(LCYC - 1);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, bus domain
logic start1, start_s, slot_hit, grant_b;
logic [31:0] ad1, ad_s;
logic [1:0] tm1, tm_s;
logic [3:0] slot1, slot_s;
logic hold1, hold_s, req1, req_s, req_seen, done_tgl;
logic dreq_tgl;
nsb_pkg::nsb_dma_cmd_t cmd_hold;
logic [31:0] rdata_hold;

always_ff @(posedge i_ref_clk)
begin
    start1 <= ~i_bus_start_n;
    start_s <= start1;
    ad1 <= i_bus_ad;
    ad_s <= ad1;
    tm1 <= i_bus_tm;
    tm_s <= tm1;
    slot1 <= i_slot_id;
    slot_s <= slot1;
    hold1 <= i_dma_hold;
    hold_s <= hold1;
    req1 <= dreq_tgl;
    req_s <= req1;
end

// Bits 23..20 never enter the compare or the decode
assign slot_hit = start_s && ad_s[`NSB_SLOT_HI:`NSB_SLOT_LO] == slot_s;

////////////////////////////////////////////////////////////////////////////////
// Bus domain state machine
nsb_pkg::nsb_state_t state, next_state;
logic [31:0] addr_lat, next_addr_lat;
logic wr_lat, next_wr_lat;
logic [1:0] cnt, next_cnt;
logic next_grant, next_req_seen, next_done_tgl, next_ack;
logic [1:0] next_status;
logic [31:0] next_ad, next_rdata_hold;
logic next_ad_oe_n, next_cs, next_dack, next_mreq, next_nmr_oe_n;
logic [7:0] next_sel;
nsb_pkg::nsb_local_t next_local;
nsb_pkg::nsb_dma_cmd_t next_mcmd;
logic dpend, own;

assign dpend = req_s != req_seen;
assign own = cmd_hold.addr[31:24] == {`NSB_SPACE_TOP, slot_s};

always_comb
begin
    next_state = state;
    next_addr_lat = addr_lat;
    next_wr_lat = wr_lat;
    next_cnt = cnt;
    next_grant = grant_b;
    next_req_seen = req_seen;
    next_done_tgl = done_tgl;
    next_ack = 1'b0;
    next_status = o_bus_status;
    next_ad = o_bus_ad;
    next_ad_oe_n = 1'b1;
    next_rdata_hold = rdata_hold;
    next_cs = o_gpib_cs;
    next_dack = o_gpib_dack;
    next_mreq = o_master_req;
    next_mcmd = o_master_cmd;
    next_sel = o_group_sel;
    next_local = o_local;
    next_nmr_oe_n = ~i_board_irq;
    case (state)
        nsb_pkg::st_idle:
        begin
            if (slot_hit)
            begin
                next_addr_lat = ad_s;
                next_wr_lat = ~tm_s[`NSB_TM_RD];
                if (grant_b)
                begin
                    next_ack = 1'b1;
                    next_status = `NSB_ST_RETRY;
                end
                else
                begin
                    next_state = nsb_pkg::st_slv;
                    next_cnt = LCNT;
                    next_sel = 8'h01 << ad_s[`NSB_GRP_HI:`NSB_GRP_LO];
                    next_cs = ad_s[`NSB_GRP_HI:`NSB_GRP_LO] == `NSB_GPIB_GRP;
                    // ROM holds 8 kbyte and mirrors over the rest of its group
                    if (ad_s[`NSB_GRP_HI:`NSB_GRP_LO] == `NSB_ROM_GRP)
                        next_local.addr = {4'h0, ad_s[`NSB_ROM_AW-1:0]};
                    else
                        next_local.addr = ad_s[16:0];
                    next_local.wdata = ad_s;
                    next_local.size = 2'h2;
                    next_local.rd = tm_s[`NSB_TM_RD];
                    next_local.wr = ~tm_s[`NSB_TM_RD];
                end
            end
            else if (grant_b && dpend)
            begin
                next_req_seen = req_s;
                if (own)
                begin
                    next_state = nsb_pkg::st_loc;
                    next_cnt = LCNT;
                    next_dack = 1'b1;
                    next_local.addr = cmd_hold.addr[16:0];
                    next_local.wdata = cmd_hold.wdata;
                    next_local.size = cmd_hold.size;
                    next_local.rd = ~cmd_hold.write;
                    next_local.wr = cmd_hold.write;
                end
                else
                begin
                    next_state = nsb_pkg::st_mst;
                    next_mreq = 1'b1;
                    next_mcmd = cmd_hold;
                end
            end
            else
            begin
                // Grant only changes when no slave cycle is starting
                next_grant = hold_s;
            end
        end
        nsb_pkg::st_slv:
        begin
            if (cnt == 2'h0)
            begin
                next_state = nsb_pkg::st_idle;
                next_ack = 1'b1;
                next_status = `NSB_ST_DONE;
                next_local.rd = 1'b0;
                next_local.wr = 1'b0;
                next_sel = 8'h00;
                next_cs = 1'b0;
                if (!wr_lat)
                begin
                    next_ad = i_local_rdata;
                    next_ad_oe_n = 1'b0;
                end
            end
            else
                next_cnt = cnt - 2'h1;
        end
        nsb_pkg::st_loc:
        begin
            if (cnt == 2'h0)
            begin
                next_state = nsb_pkg::st_idle;
                next_rdata_hold = i_local_rdata;
                next_done_tgl = ~done_tgl;
                next_dack = 1'b0;
                next_local.rd = 1'b0;
                next_local.wr = 1'b0;
            end
            else
                next_cnt = cnt - 2'h1;
        end
        nsb_pkg::st_mst:
        begin
            if (i_master_done)
            begin
                next_state = nsb_pkg::st_idle;
                next_mreq = 1'b0;
                next_rdata_hold = i_master_rdata;
                next_done_tgl = ~done_tgl;
            end
        end
        default:
            next_state = nsb_pkg::st_idle;
    endcase
    // The core may own the bus mid cycle too; a dropped start would hang the host
    if (slot_hit && grant_b)
    begin
        next_ack = 1'b1;
        next_status = `NSB_ST_RETRY;
    end
end

always_ff @(posedge i_ref_clk)
begin
    if (i_reset)
    begin
        state <= nsb_pkg::st_idle;
        addr_lat <= 32'h0000_0000;
        wr_lat <= 1'b0;
        cnt <= 2'h0;
        grant_b <= 1'b0;
        req_seen <= 1'b0;
        done_tgl <= 1'b0;
        o_bus_ack <= 1'b0;
        o_bus_status <= `NSB_ST_DONE;
        o_bus_ad <= 32'h0000_0000;
        o_bus_ad_oe_n <= 1'b1;
        rdata_hold <= 32'h0000_0000;
        o_gpib_cs <= 1'b0;
        o_gpib_dack <= 1'b0;
        o_master_req <= 1'b0;
        o_master_cmd <= '0;
        o_group_sel <= 8'h00;
        o_local <= '0;
        o_nonmaster_interrupt_request <= 1'b0;
        o_nonmaster_interrupt_request_oe_n <= 1'b1;
    end
    else
    begin
        state <= next_state;
        addr_lat <= next_addr_lat;
        wr_lat <= next_wr_lat;
        cnt <= next_cnt;
        grant_b <= next_grant;
        req_seen <= next_req_seen;
        done_tgl <= next_done_tgl;
        o_bus_ack <= next_ack;
        o_bus_status <= next_status;
        o_bus_ad <= next_ad;
        o_bus_ad_oe_n <= next_ad_oe_n;
        rdata_hold <= next_rdata_hold;
        o_gpib_cs <= next_cs;
        o_gpib_dack <= next_dack;
        o_master_req <= next_mreq;
        o_master_cmd <= next_mcmd;
        o_group_sel <= next_sel;
        o_local <= next_local;
        o_nonmaster_interrupt_request <= 1'b0;
        o_nonmaster_interrupt_request_oe_n <= next_nmr_oe_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Core domain: grant, command hand-off by toggle, completion back
logic drst1, drst, g1, d1, d2, d3, busy;
logic next_dreq_tgl, next_busy, next_done;
nsb_pkg::nsb_dma_cmd_t next_cmd_hold;
logic [31:0] next_drdata;

always_ff @(posedge i_dma_clk)
begin
    drst1 <= i_reset;
    drst <= drst1;
    g1 <= grant_b;
    o_local_bus_grant <= g1;
    d1 <= done_tgl;
    d2 <= d1;
    d3 <= d2;
end

always_comb
begin
    next_dreq_tgl = dreq_tgl;
    next_busy = busy;
    next_done = 1'b0;
    next_cmd_hold = cmd_hold;
    next_drdata = o_dma_rdata;
    // Commands before the grant is seen are dropped
    if (i_dma_cmd_valid && o_local_bus_grant && !busy)
    begin
        next_cmd_hold = i_dma_cmd;
        next_dreq_tgl = ~dreq_tgl;
        next_busy = 1'b1;
    end
    else if (busy && d2 != d3)
    begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_drdata = rdata_hold;
    end
end

// Held words change only while no toggle is in flight
always_ff @(posedge i_dma_clk)
begin
    if (drst)
    begin
        dreq_tgl <= 1'b0;
        busy <= 1'b0;
        o_dma_done <= 1'b0;
        cmd_hold <= '0;
        o_dma_rdata <= 32'h0000_0000;
    end
    else
    begin
        dreq_tgl <= next_dreq_tgl;
        busy <= next_busy;
        o_dma_done <= next_done;
        cmd_hold <= next_cmd_hold;
        o_dma_rdata <= next_drdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Checks
slot_match_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_idle && !slot_hit && !dpend |=> !o_bus_ack)
    else $error("ack without slot match");
addr_stable_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_slv && $past(state) == nsb_pkg::st_slv |-> $stable(addr_lat))
    else $error("latched address moved");
group_decode_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_slv |-> o_group_sel == (8'h01 << addr_lat[19:17]))
    else $error("group select wrong");
slave_done_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(state == nsb_pkg::st_slv) |-> ##[1:4] o_bus_ack && o_bus_status == `NSB_ST_DONE)
    else $error("slave access did not finish");
retry_granted_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_idle && slot_hit && grant_b
    |=> o_bus_ack && o_bus_status == `NSB_ST_RETRY && state == nsb_pkg::st_idle)
    else $error("no retry while granted");
retry_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (state == nsb_pkg::st_loc || state == nsb_pkg::st_mst) && slot_hit
    |=> o_bus_ack && o_bus_status == `NSB_ST_RETRY)
    else $error("no retry during core cycle");
irq_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_board_irq |=> !o_nonmaster_interrupt_request_oe_n)
    else $error("interrupt line not driven");
master_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_mst && !i_master_done |=> o_master_req && state == nsb_pkg::st_mst)
    else $error("master request dropped early");
local_only_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_loc |-> !o_master_req && o_gpib_dack)
    else $error("local cycle went to the bus");
grant_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    state == nsb_pkg::st_idle && !hold_s && !slot_hit |=> !grant_b)
    else $error("grant held after release");
reset_clear_a: assert property (@(posedge i_ref_clk)
    i_reset |=> !grant_b && !o_master_req && state == nsb_pkg::st_idle)
    else $error("reset state wrong");
endmodule

// ---- hw/nsb_defines.svh ----
// Constants for the slot bus slave and local bus arbiter.
// Assumes a 10 MHz slot bus clock; included by its bare name.
`ifndef NSB_DEFINES_SVH
`define NSB_DEFINES_SVH
`define NSB_SLOT_HI 27
`define NSB_SLOT_LO 24
`define NSB_GRP_HI 19
`define NSB_GRP_LO 17
`define NSB_ROM_GRP 3'h7
`define NSB_GPIB_GRP 3'h0
`define NSB_ROM_AW 13
`define NSB_SPACE_TOP 4'hf
`define NSB_TM_RD 1
`define NSB_ST_DONE 2'h0
`define NSB_ST_RETRY 2'h3
`define NSB_CLK_NS 100
`define NSB_LOCAL_NS 300
`define NSB_LOCAL_CYC ((`NSB_LOCAL_NS + `NSB_CLK_NS - 1) / `NSB_CLK_NS)
`endif

// ---- hw/nsb_pkg.sv ----
// Types shared by the slot bus slave and local bus arbiter.
// Assumes nothing beyond the defines header.
package nsb_pkg;
    // Size: 0 byte, 1 half word, 2 word
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic write;
        logic [1:0] size;
    } nsb_dma_cmd_t;
    typedef struct packed {
        logic [16:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
        logic rd;
        logic wr;
    } nsb_local_t;
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_slv = 4'h2,
        st_loc = 4'h4,
        st_mst = 4'h8
    } nsb_state_t;
endpackage

// ---- test/nsb_host_model.sv ----
// Far side model: answers master operations and the local bus read data.
// Assumes the bridge's registered outputs on the i_ref_clk domain.
`timescale 1ns/100ps
module nsb_host_model
(
    input wire logic i_ref_clk,
    input wire logic i_master_req,
    input wire nsb_pkg::nsb_dma_cmd_t i_master_cmd,
    input wire nsb_pkg::nsb_local_t i_local,
    input wire logic [3:0] i_wait,
    output logic o_master_done,
    output logic [31:0] o_master_rdata,
    output logic [31:0] o_local_rdata
);
    int cnt;
    initial
    begin
        cnt = 0;
        o_master_done = 0;
        o_master_rdata = 32'h0000_0000;
        o_local_rdata = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////
    // Stale data is inverted every cycle so a late sample cannot pass by luck
    always @(posedge i_ref_clk)
    begin
        o_master_done <= 1'b0;
        if (i_local.rd)
            o_local_rdata <= {15'h0000, i_local.addr} ^ 32'h5a5a_0000;
        else
            o_local_rdata <= ~o_local_rdata;
        if (i_master_req && !o_master_done && cnt >= i_wait)
        begin
            o_master_done <= 1'b1;
            o_master_rdata <= i_master_cmd.addr ^ 32'hc3c3_3c3c;
            cnt = 0;
        end
        else
        begin
            o_master_rdata <= ~o_master_rdata;
            cnt = i_master_req ? cnt + 1 : 0;
        end
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the slot bus slave and local bus arbiter.
// Assumes the host model stands on the master and local bus side.
`timescale 1ns/100ps
module tb;
    logic i_ref_clk = 0, i_dma_clk = 0, i_reset = 1, i_bus_start_n = 1, i_board_irq = 0;
    logic [31:0] i_bus_ad = 0, i_local_rdata, i_master_rdata, o_bus_ad, o_dma_rdata;
    logic [1:0] i_bus_tm = 0, o_bus_status, lsz;
    logic [3:0] i_slot_id = 0, mwait = 0;
    logic i_master_done, i_dma_hold = 0, i_dma_cmd_valid = 0, o_bus_ad_oe_n, o_bus_ack;
    logic o_nonmaster_interrupt_request, o_nonmaster_interrupt_request_oe_n;
    logic o_gpib_cs, o_gpib_dack, o_master_req, o_local_bus_grant, o_dma_done;
    logic [7:0] o_group_sel;
    nsb_pkg::nsb_local_t o_local;
    nsb_pkg::nsb_dma_cmd_t o_master_cmd, i_dma_cmd = '0;
    int errors = 0, compares = 0, cyc = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    always #62.5 i_dma_clk = ~i_dma_clk;
    nsb_bridge DUT (.i_ref_clk, .i_reset, .i_dma_clk, .i_bus_start_n, .i_bus_ad, .i_bus_tm,
        .i_slot_id, .o_bus_ad, .o_bus_ad_oe_n, .o_bus_ack, .o_bus_status, .i_board_irq,
        .o_nonmaster_interrupt_request, .o_nonmaster_interrupt_request_oe_n, .o_local,
        .o_group_sel, .o_gpib_cs, .o_gpib_dack, .i_local_rdata, .o_master_req, .o_master_cmd,
        .i_master_done, .i_master_rdata, .i_dma_hold, .i_dma_cmd_valid, .i_dma_cmd,
        .o_local_bus_grant, .o_dma_done, .o_dma_rdata);
    nsb_host_model host (.i_ref_clk, .i_master_req(o_master_req), .i_master_cmd(o_master_cmd),
        .i_local(o_local), .i_wait(mwait), .o_master_done(i_master_done),
        .o_master_rdata(i_master_rdata), .o_local_rdata(i_local_rdata));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end
    // One slave cycle; the address stays on the lines until the answer
    task automatic slave(input logic [31:0] a, input logic rd, output logic ok,
        output logic [31:0] dat, output logic [1:0] st, output logic [7:0] sel,
        output logic cs);
        int n;
        sel = 0;
        cs = 0;
        dat = 'x;
        @(posedge i_ref_clk);
        i_bus_start_n <= 0;
        i_bus_ad <= a;
        i_bus_tm <= {rd, 1'b0};
        @(posedge i_ref_clk);
        i_bus_start_n <= 1;
        for (n = 0; n < 10 && o_bus_ack !== 1'b1; n++)
        begin
            @(posedge i_ref_clk);
            sel |= o_group_sel;
            cs |= o_gpib_cs;
            if (o_local.wr === 1'b1)
                dat = o_local.wdata;
        end
        ok = (o_bus_ack === 1'b1);
        st = o_bus_status;
        if (rd)
            dat = o_bus_ad_oe_n ? 'x : o_bus_ad;
        i_bus_ad <= ~a;
    endtask
    // One core command, issued and awaited on the core clock
    task automatic dma(input logic [31:0] a, input logic wr, input logic [1:0] sz,
        output logic [31:0] rd, output logic dk, output logic mr);
        int n;
        dk = 0;
        lsz = 2'h3;
        mr = 0;
        @(posedge i_dma_clk);
        i_dma_cmd_valid <= 1;
        i_dma_cmd <= {a, $urandom, wr, sz};
        @(posedge i_dma_clk);
        i_dma_cmd_valid <= 0;
        for (n = 0; n < 80 && o_dma_done !== 1'b1; n++)
        begin
            @(posedge i_dma_clk);
            dk |= o_gpib_dack;
            mr |= o_master_req;
            if (o_gpib_dack === 1'b1)
                lsz = o_local.size;
        end
        rd = o_dma_done ? o_dma_rdata : 'x;
    endtask
    task automatic await_grant(input logic lvl);
        int n;
        for (n = 0; n < 40 && o_local_bus_grant !== lvl; n++)
            @(posedge i_dma_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] a, d, r, x;
        logic [1:0] st;
        logic [7:0] sel;
        logic ok, cs, dk, mr;
        int g;
        r = $urandom(43335);
        i_slot_id = 4'h9 + 4'($urandom % 6);
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 0;
        @(posedge i_ref_clk);
        chk({o_local_bus_grant, o_master_req, o_bus_ack, o_bus_ad_oe_n}, 32'h1);
        for (g = 0; g < 16; g++)
        begin
            a = {4'($urandom), i_slot_id, 4'($urandom), 3'(g / 2), 17'($urandom)};
            slave(a, g[0], ok, d, st, sel, cs);
            chk({ok, st, sel}, {1'b1, 2'h0, 8'h01 << (g / 2)});
            chk(cs, (g / 2) == 0);
            x = {15'h0000, (g / 2 == 7) ? {4'h0, a[12:0]} : a[16:0]} ^ 32'h5a5a_0000;
            chk(d, g[0] ? x : a);
        end
        slave({4'h0, i_slot_id ^ 4'h1, 24'h0e_0000}, 1, ok, d, st, sel, cs);
        chk({ok, sel}, 0);
        i_board_irq <= 1;
        repeat (4) @(posedge i_ref_clk);
        chk({o_nonmaster_interrupt_request_oe_n, o_nonmaster_interrupt_request}, 0);
        i_board_irq <= 0;
        repeat (4) @(posedge i_ref_clk);
        chk(o_nonmaster_interrupt_request_oe_n, 1);
        @(posedge i_dma_clk);
        i_dma_hold <= 1;
        await_grant(1);
        chk(o_local_bus_grant, 1);
        a = {4'h0, i_slot_id, 24'h00_0010};
        slave(a, 1, ok, d, st, sel, cs);
        chk({ok, st, cs, sel}, {1'b1, 2'h3, 9'h0});
        for (g = 0; g < 4; g++)
        begin
            r = {4'hf, i_slot_id, 8'h00, 3'h0, 13'($urandom)};
            dma(r, g[0], 2'(g / 2), d, dk, mr);
            chk({dk, mr}, 2'b10);
            chk(lsz, 2'(g / 2));
            if (!g[0])
                chk(d, {19'h0_0000, r[12:0]} ^ 32'h5a5a_0000);
        end
        for (g = 0; g < 2; g++)
        begin
            mwait <= 4'(g * 5);
            r = {4'h0, 4'($urandom), 24'($urandom)};
            dma(r, 0, 2'h2, d, dk, mr);
            chk({dk, mr}, 2'b01);
            chk(d, r ^ 32'hc3c3_3c3c);
        end
        // Host access while a master operation runs must be refused
        r = {4'h0, 4'($urandom), 24'($urandom)};
        fork
            dma(r, 0, 2'h2, d, dk, mr);
            begin
                repeat (4) @(posedge i_ref_clk);
                slave(a, 1, ok, x, st, sel, cs);
            end
        join
        chk({dk, mr}, 2'b01);
        chk(d, r ^ 32'hc3c3_3c3c);
        chk({ok, st, cs, sel}, {1'b1, 2'h3, 9'h0});
        @(posedge i_dma_clk);
        i_dma_hold <= 0;
        await_grant(0);
        chk(o_local_bus_grant, 0);
        slave(a, 1, ok, d, st, sel, cs);
        chk({ok, st}, 3'b100);
        chk(d, {19'h0_0000, a[12:0]} ^ 32'h5a5a_0000);
        close_out();
    end
endmodule
